// >>> inc/sleep_wake_defs.svh
// offsets, field positions, reset values and timing counts for the sleep/wake block
`ifndef SLEEP_WAKE_DEFS_SVH
`define SLEEP_WAKE_DEFS_SVH
`define OFS_IRQ_CONTROL  12'h000
`define OFS_PERIPH_EN_A  12'h004
`define OFS_PERIPH_EN_B  12'h008
`define OFS_PERIPH_FLG_A 12'h00c
`define OFS_PERIPH_FLG_B 12'h010
`define OFS_CORE_STATUS  12'h014
`define OFS_WDT_CFG      12'h018
`define OFS_PRESCALE_CFG 12'h01c
`define BIT_UV           7
`define BIT_OC           5
`define BIT_OV           4
`define BIT_VIN          1
`define FLG_B_MASK       8'hb2
`define BIT_GLOBAL_EN    7
`define BIT_PERIPH_EN    6
`define BIT_INTE         4
`define BIT_IOCE         3
`define BIT_INTF         1
`define BIT_IOCF         0
`define BIT_ADIE         6
`define BIT_TMR1IE       0
`define BIT_POWERDOWN    3
`define BIT_WDT_EXPIRY   4
`define STATUS_RESET     8'h18
`define WDT_TIMEOUT_MS   18
`define CLK_HZ           20000000
`define WDT_CYCLES       ((`WDT_TIMEOUT_MS * `CLK_HZ) / 1000)
`endif

// >>> inc/sleep_wake_pkg.sv
// types for the sleep/wake block
package sleep_wake_pkg;
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_SLEEP = 3'b010,
		ST_WAKE  = 3'b100
	} pwr_state_t;
	typedef logic [7:0] byte_t;
endpackage

// >>> logic/sync2.sv
// two-flop synchroniser for pin-side levels
`timescale 1ns/100ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// >>> logic/sleep_wake.sv
// sleep entry, wake control, watchdog and peripheral error flags
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "sleep_wake_defs.svh"
module sleep_wake #(
	parameter int WDT_CYCLES = `WDT_CYCLES
) (
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite write
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// core side
	input  wire logic                 halt_exec,
	input  wire logic                 clrwdt_exec,
	input  wire logic                 wdt_enable,
	input  wire logic                 ext_reset_enable,
	input  wire logic [12:0]          halt_pc,
	// event sources, asynchronous
	input  wire logic                 ext_reset_pin_n,
	input  wire logic                 uv_error,
	input  wire logic                 oc_error,
	input  wire logic                 ov_error,
	input  wire logic                 vin_low,
	input  wire logic                 ext_int_event,
	input  wire logic                 pin_change_event,
	input  wire logic                 adc_done_event,
	input  wire logic                 tmr1_async_event,
	// control outputs
	output sleep_wake_pkg::pwr_state_t pwr_state,
	output logic                      core_asleep,
	output logic                      halt_was_nop,
	output logic                      device_reset,
	output logic                      vector_irq,
	output logic [12:0]               prefetch_pc,
	output logic [12:0]               stack_push_pc,
	output logic                      stack_push,
	output logic                      pin_hold
);
	import sleep_wake_pkg::*;

	pwr_state_t state_reg;
	byte_t      irq_control_reg;
	byte_t      periph_enables_a;
	byte_t      periph_enables_b;
	byte_t      periph_flags_a;
	byte_t      periph_flags_b;
	byte_t      status_reg;
	byte_t      prescale_cfg_reg;
	logic [31:0] wdt_count_reg;
	logic        wdt_expire;
	logic [8:0]  pin_sync;
	logic        aw_taken_reg;
	logic        w_taken_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        wr_fire;
	logic        rst_req;
	logic        pending;
	logic        periph_pend;
	logic        wake_req;
	logic        halt_go;

	sync2 #(.W(9)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({!ext_reset_pin_n, uv_error, oc_error, ov_error, vin_low,
		           ext_int_event, pin_change_event, adc_done_event, tmr1_async_event}),
		.q       (pin_sync)
	);

	// pin enters inverted so a cleared synchroniser reads as an idle pin, same asleep or awake
	assign rst_req = ext_reset_enable && pin_sync[8];

	// write channels accepted independently, response after both
	assign wr_fire = aw_taken_reg && w_taken_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_taken_reg  <= 1'b0;
			w_taken_reg   <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			awaddr_reg    <= 12'h000;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
		end else begin
			s_axi_awready <= !aw_taken_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_taken_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_taken_reg <= 1'b1;
				awaddr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_taken_reg <= 1'b1;
				wdata_reg   <= s_axi_wdata;
				wstrb_reg   <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_reg[11:2] <= `OFS_PRESCALE_CFG >> 2) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_taken_reg <= 1'b0;
				w_taken_reg  <= 1'b0;
			end
		end
	end

	logic wr_lane0;
	assign wr_lane0 = wr_fire && wstrb_reg[0];

	// plain read/write control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_enables_a <= 8'h00;
			periph_enables_b <= 8'h00;
			prescale_cfg_reg <= 8'hff;
		end else if (wr_lane0) begin
			case (awaddr_reg)
				`OFS_PERIPH_EN_A:  periph_enables_a <= wdata_reg[7:0] & 8'h73;
				`OFS_PERIPH_EN_B:  periph_enables_b <= wdata_reg[7:0] & `FLG_B_MASK;
				`OFS_PRESCALE_CFG: prescale_cfg_reg <= wdata_reg[7:0];
				default: ;
			endcase
		end
	end

	// error flags: hardware set beats software clear, uv/oc/ov sticky until written zero, vin follows its pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_flags_b <= 8'h00;
		end else begin
			if (wr_lane0 && awaddr_reg == `OFS_PERIPH_FLG_B)
				periph_flags_b <= wdata_reg[7:0] & periph_flags_b & `FLG_B_MASK;
			if (pin_sync[7])
				periph_flags_b[`BIT_UV] <= 1'b1;
			if (pin_sync[6])
				periph_flags_b[`BIT_OC] <= 1'b1;
			if (pin_sync[5])
				periph_flags_b[`BIT_OV] <= 1'b1;
			periph_flags_b[`BIT_VIN] <= pin_sync[4];
		end
	end

	// wake-capable flags: adc done and asynchronous timer1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_flags_a <= 8'h00;
		end else begin
			if (wr_lane0 && awaddr_reg == `OFS_PERIPH_FLG_A)
				periph_flags_a <= wdata_reg[7:0] & periph_flags_a & 8'h73;
			if (pin_sync[1])
				periph_flags_a[`BIT_ADIE] <= 1'b1;
			if (pin_sync[0])
				periph_flags_a[`BIT_TMR1IE] <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_control_reg <= 8'h00;
		end else begin
			if (wr_lane0 && awaddr_reg == `OFS_IRQ_CONTROL)
				irq_control_reg <= wdata_reg[7:0] & (irq_control_reg | 8'hfc);
			if (pin_sync[3])
				irq_control_reg[`BIT_INTF] <= 1'b1;
			if (pin_sync[2])
				irq_control_reg[`BIT_IOCF] <= 1'b1;
		end
	end

	// int, pin change, adc, timer1 and the uv/oc/ov/vin flags raise pending; peripheral ones need the peripheral enable
	assign periph_pend = irq_control_reg[`BIT_PERIPH_EN] &&
		(|(periph_flags_a & periph_enables_a & 8'h41) ||
		 |(periph_flags_b & periph_enables_b & `FLG_B_MASK));
	assign pending = periph_pend ||
		(irq_control_reg[`BIT_INTE] && irq_control_reg[`BIT_INTF]) ||
		(irq_control_reg[`BIT_IOCE] && irq_control_reg[`BIT_IOCF]);

	assign wake_req = pending || (wdt_enable && wdt_expire);
	assign halt_go  = (state_reg == ST_RUN) && halt_exec && !pending;

	always_ff @(posedge aclk) begin
		if (!aresetn || rst_req) begin
			state_reg <= ST_RUN;
		end else begin
			case (state_reg)
				ST_RUN:   if (halt_go) state_reg <= ST_SLEEP;
				ST_SLEEP: if (wake_req) state_reg <= ST_WAKE;
				ST_WAKE:  state_reg <= ST_RUN;
				default:  state_reg <= ST_RUN;
			endcase
		end
	end

	// watchdog: cleared on sleep entry, on every wake and by clear instruction
	assign wdt_expire = (wdt_count_reg == WDT_CYCLES - 1);
	always_ff @(posedge aclk) begin
		if (!aresetn || rst_req) begin
			wdt_count_reg <= 32'h0000_0000;
		end else if (halt_go || state_reg == ST_WAKE || clrwdt_exec || !wdt_enable ||
			(state_reg == ST_SLEEP && wake_req)) begin
			wdt_count_reg <= 32'h0000_0000;
		end else if (wdt_expire) begin
			wdt_count_reg <= 32'h0000_0000;
		end else begin
			wdt_count_reg <= wdt_count_reg + 32'h0000_0001;
		end
	end

	// status: powerdown bit cleared and expiry bit set on entry, expiry cleared on timeout
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= `STATUS_RESET;
		end else begin
			if (clrwdt_exec)
				status_reg <= `STATUS_RESET;
			if (halt_go) begin
				status_reg[`BIT_POWERDOWN] <= 1'b0;
				status_reg[`BIT_WDT_EXPIRY] <= 1'b1;
			end else if (wdt_enable && wdt_expire) begin
				status_reg[`BIT_WDT_EXPIRY] <= 1'b0;
			end
		end
	end

	// watchdog expiry while awake resets the core, asleep it only wakes
	// prefetch next address on halt; interrupt pushes only return pc
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_state     <= ST_RUN;
			core_asleep   <= 1'b0;
			halt_was_nop  <= 1'b0;
			device_reset  <= 1'b1;
			vector_irq    <= 1'b0;
			prefetch_pc   <= 13'h0000;
			stack_push_pc <= 13'h0000;
			stack_push    <= 1'b0;
			pin_hold      <= 1'b0;
		end else begin
			pwr_state    <= state_reg;
			core_asleep  <= (state_reg == ST_SLEEP);
			pin_hold     <= (state_reg == ST_SLEEP);
			halt_was_nop <= halt_exec && state_reg == ST_RUN && pending;
			device_reset <= rst_req ||
				(state_reg == ST_RUN && wdt_enable && wdt_expire);
			if (halt_exec && state_reg == ST_RUN)
				prefetch_pc <= halt_pc + 13'h0001;
			vector_irq <= (state_reg == ST_WAKE) && pending &&
				irq_control_reg[`BIT_GLOBAL_EN];
			stack_push <= (state_reg == ST_WAKE) && pending &&
				irq_control_reg[`BIT_GLOBAL_EN];
			if ((state_reg == ST_WAKE) && pending)
				stack_push_pc <= prefetch_pc + 13'h0001;
		end
	end

	// read channel: one cycle to answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				case (s_axi_araddr)
					`OFS_IRQ_CONTROL:  s_axi_rdata <= {24'h0, irq_control_reg};
					`OFS_PERIPH_EN_A:  s_axi_rdata <= {24'h0, periph_enables_a};
					`OFS_PERIPH_EN_B:  s_axi_rdata <= {24'h0, periph_enables_b};
					`OFS_PERIPH_FLG_A: s_axi_rdata <= {24'h0, periph_flags_a};
					`OFS_PERIPH_FLG_B: s_axi_rdata <= {24'h0, periph_flags_b};
					`OFS_CORE_STATUS:  s_axi_rdata <= {24'h0, status_reg};
					`OFS_WDT_CFG:      s_axi_rdata <= {31'h0, wdt_enable};
					`OFS_PRESCALE_CFG: s_axi_rdata <= {24'h0, prescale_cfg_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// checks
	sequence seq_enter;
		halt_exec && state_reg == ST_RUN && !pending && !rst_req;
	endsequence
	sequence seq_asleep;
		state_reg == ST_SLEEP;
	endsequence

	chk_flag_uv_set: assert property (@(posedge aclk) disable iff (!aresetn)
		pin_sync[7] |=> periph_flags_b[`BIT_UV])
		else $error("undervoltage flag not set");
	chk_flag_oc_set: assert property (@(posedge aclk) disable iff (!aresetn)
		pin_sync[6] |=> periph_flags_b[`BIT_OC])
		else $error("overcurrent flag not set");
	chk_flag_ov_set: assert property (@(posedge aclk) disable iff (!aresetn)
		pin_sync[5] |=> periph_flags_b[`BIT_OV])
		else $error("overvoltage flag not set");
	chk_vin_status: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 periph_flags_b[`BIT_VIN] == $past(pin_sync[4]))
		else $error("supply status wrong");
	chk_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(periph_flags_b & 8'h4d) == 8'h00)
		else $error("unimplemented bit set");
	chk_sleep_entry: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_enter |=> seq_asleep ##0 (wdt_count_reg == 32'h0) ##0 !status_reg[`BIT_POWERDOWN])
		else $error("sleep entry wrong");
	chk_status_entry: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_enter |=> status_reg[`BIT_WDT_EXPIRY] && !status_reg[`BIT_POWERDOWN])
		else $error("status bits on entry wrong");
	chk_halt_nop: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == ST_RUN && halt_exec && pending && !rst_req) |=> state_reg == ST_RUN)
		else $error("halt not a no-op");
	chk_wake_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_asleep ##0 wake_req && !rst_req) |=> state_reg == ST_WAKE && wdt_count_reg == 32'h0)
		else $error("wake did not clear watchdog");
	chk_prefetch_next: assert property (@(posedge aclk) disable iff (!aresetn)
		(halt_exec && state_reg == ST_RUN) |=> prefetch_pc == $past(halt_pc) + 13'h0001)
		else $error("prefetch address wrong");
	chk_pin_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_asleep |=> pin_hold)
		else $error("pins not held asleep");
	chk_reset_wake: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_req |=> state_reg == ST_RUN && device_reset)
		else $error("pin reset not full reset");
endmodule

// >>> test/sleep_wake_test.sv
// self-checking bench for the sleep/wake block
`timescale 1ns/100ps
`include "sleep_wake_defs.svh"
module sleep_wake_test;
	import sleep_wake_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic halt_exec = 0, clrwdt = 0, wdt_en = 0, xrst_en = 0, xrst_n = 1;
	logic [12:0] hpc = 0;
	logic uv = 0, oc = 0, ov = 0, vin = 0, ext_int = 0, pchg = 0, adc = 0, tmr1 = 0;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	pwr_state_t pstate;
	wire logic asleep, nop, dev_rst, vec, push, hold;
	wire logic [12:0] pre_pc, push_pc;
	int fail_count = 0, checks = 0, seed = 34165, cyc = 0;
	int vec_n = 0, push_n = 0, nop_n = 0, rst_n = 0;
	logic [31:0] d, s0, r;
	logic [1:0] resp;
	logic [7:0] e;

	sleep_wake #(.WDT_CYCLES(64)) i_sleep_wake (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .halt_exec(halt_exec),
		.clrwdt_exec(clrwdt), .wdt_enable(wdt_en), .ext_reset_enable(xrst_en),
		.halt_pc(hpc), .ext_reset_pin_n(xrst_n), .uv_error(uv), .oc_error(oc),
		.ov_error(ov), .vin_low(vin), .ext_int_event(ext_int),
		.pin_change_event(pchg), .adc_done_event(adc), .tmr1_async_event(tmr1),
		.pwr_state(pstate), .core_asleep(asleep), .halt_was_nop(nop),
		.device_reset(dev_rst), .vector_irq(vec), .prefetch_pc(pre_pc),
		.stack_push_pc(push_pc), .stack_push(push), .pin_hold(hold));

	always #25 aclk = ~aclk;

	// pulse counters and hang guard
	always @(posedge aclk) begin
		if (vec === 1'b1) vec_n++;
		if (push === 1'b1) push_n++;
		if (nop === 1'b1) nop_n++;
		if (dev_rst === 1'b1) rst_n++;
		cyc++;
		if (cyc > 30000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge aclk);
		awaddr <= a; wdata <= {24'h0, v}; wstrb <= 4'h1;
		awvalid <= 1; wvalid <= 1; bready <= 1;
		do begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 0;
			if (wvalid && wready === 1'b1) wvalid <= 0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 0;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 0;
		end while (rvalid !== 1'b1);
		d = rdata; resp = rresp;
		rready <= 0;
	endtask

	task automatic halt(input logic [12:0] pc);
		@(posedge aclk);
		hpc <= pc; halt_exec <= 1;
		@(posedge aclk);
		halt_exec <= 0;
	endtask

	task automatic pulse_ext();
		@(posedge aclk);
		ext_int <= 1;
		repeat (4) @(posedge aclk);
		ext_int <= 0;
	endtask

	task automatic wait_sleep(input logic lvl);
		int n;
		n = 0;
		while (asleep !== lvl && n < 200) begin
			@(posedge aclk);
			n++;
		end
		repeat (3) @(posedge aclk);
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		rd(`OFS_CORE_STATUS); chk(d, 32'h18);
		rd(`OFS_PERIPH_FLG_B); chk(d, 32'h0);
		rd(`OFS_PRESCALE_CFG); chk(d, 32'hff);
		rd(12'h0f0); chk({30'h0, resp}, 32'h2);
		chk(d, 32'h0);
		wr(12'h0f0, 8'h00); chk({30'h0, resp}, 32'h2);
		done("reset");
		// random fault mixes, uv/oc/ov sticky until written zero
		repeat (6) begin
			r = $random(seed);
			@(posedge aclk);
			{uv, oc, ov, vin} <= r[3:0];
			e = {r[3], 1'b0, r[2], r[1], 2'b00, r[0], 1'b0};
			repeat (6) @(posedge aclk);
			rd(`OFS_PERIPH_FLG_B); chk(d, {24'h0, e});
			@(posedge aclk);
			{uv, oc, ov, vin} <= 4'h0;
			repeat (6) @(posedge aclk);
			rd(`OFS_PERIPH_FLG_B); chk(d & 32'hb0, {24'h0, e & 8'hb0});
			wr(`OFS_PERIPH_FLG_B, 8'h00);
			rd(`OFS_PERIPH_FLG_B); chk(d, 32'h0);
		end
		done("flags");
		// halt, then external interrupt wake without global enable
		wr(`OFS_IRQ_CONTROL, 8'h10); chk({30'h0, resp}, 32'h0);
		s0 = $random(seed) & 32'h0ffe;
		halt(s0[12:0]);
		wait_sleep(1);
		chk(asleep, 1);
		chk(hold, 1);
		chk(pre_pc, s0 + 1);
		chk(pstate, ST_SLEEP);
		rd(`OFS_CORE_STATUS); chk(d & 32'h18, 32'h10);
		e = vec_n;
		pulse_ext();
		wait_sleep(0);
		chk(asleep, 0);
		chk(vec_n, e);
		done("wake_int");
		// wake with global enable vectors and pushes the return address
		wr(`OFS_IRQ_CONTROL, 8'h90);
		e = push_n;
		halt(13'h0100);
		wait_sleep(1);
		pulse_ext();
		wait_sleep(0);
		chk(asleep, 0);
		chk(vec_n, 1);
		chk(push_n, e + 1);
		chk(push_pc, 32'h0102);
		done("wake_vec");
		// pending enabled flag turns halt into a no-op
		wr(`OFS_IRQ_CONTROL, 8'h12);
		rd(`OFS_CORE_STATUS); s0 = d;
		e = nop_n;
		halt(13'h0200);
		repeat (5) @(posedge aclk);
		chk(nop_n, e + 1);
		chk(asleep, 0);
		rd(`OFS_CORE_STATUS); chk(d, s0);
		wr(`OFS_IRQ_CONTROL, 8'h00);
		done("halt_nop");
		// peripheral wake needs the peripheral enable bit
		wr(`OFS_PERIPH_EN_B, 8'h80);
		halt(13'h0300);
		wait_sleep(1);
		@(posedge aclk);
		uv <= 1;
		repeat (20) @(posedge aclk);
		chk(asleep, 1);
		wr(`OFS_IRQ_CONTROL, 8'h40);
		wait_sleep(0);
		chk(asleep, 0);
		wr(`OFS_PERIPH_FLG_B, 8'h00);
		rd(`OFS_PERIPH_FLG_B); chk(d & 32'h80, 32'h80);
		@(posedge aclk);
		uv <= 0;
		wr(`OFS_PERIPH_FLG_B, 8'h00);
		wr(`OFS_IRQ_CONTROL, 8'h00);
		done("wake_periph");
		// pin-change, adc and timer1 wake paths
		wr(`OFS_PERIPH_EN_A, 8'h41);
		for (int k = 0; k < 3; k++) begin
			wr(`OFS_IRQ_CONTROL, k == 0 ? 8'h08 : 8'h40);
			halt(13'h0700);
			wait_sleep(1);
			chk(asleep, 1);
			@(posedge aclk);
			{pchg, adc, tmr1} <= 3'b100 >> k;
			repeat (4) @(posedge aclk);
			{pchg, adc, tmr1} <= 3'b000;
			wait_sleep(0);
			chk(asleep, 0);
			wr(`OFS_IRQ_CONTROL, 8'h00);
			wr(`OFS_PERIPH_FLG_A, 8'h00);
		end
		done("wake_other");
		// watchdog: halt clears the count, expiry wakes without reset
		@(posedge aclk);
		wdt_en <= 1; clrwdt <= 1;
		@(posedge aclk);
		clrwdt <= 0;
		repeat (40) @(posedge aclk);
		e = rst_n;
		halt(13'h0400);
		repeat (40) @(posedge aclk);
		chk(asleep, 1);
		wait_sleep(0);
		chk(asleep, 0);
		chk(rst_n, e);
		repeat (40) @(posedge aclk);
		chk(rst_n, e);
		repeat (60) @(posedge aclk);
		chk(rst_n > e, 1);
		@(posedge aclk);
		wdt_en <= 0;
		done("watchdog");
		// pin reset while asleep is a full reset
		repeat (10) @(posedge aclk);
		@(posedge aclk);
		xrst_en <= 1;
		halt(13'h0500);
		wait_sleep(1);
		e = rst_n;
		@(posedge aclk);
		xrst_n <= 0;
		repeat (6) @(posedge aclk);
		xrst_n <= 1;
		wait_sleep(0);
		chk(rst_n > e, 1);
		chk(asleep, 0);
		done("pin_reset");
		// power-on reset in mid-sleep
		repeat (10) @(posedge aclk);
		halt(13'h0600);
		wait_sleep(1);
		@(posedge aclk);
		uv <= 1;
		repeat (6) @(posedge aclk);
		aresetn <= 0; uv <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk(asleep, 0);
		chk(pstate, ST_RUN);
		rd(`OFS_PERIPH_FLG_B); chk(d, 32'h0);
		done("por");
		stop_test();
	end
endmodule
